// ===== rtl/data_space_io_decoder.sv
// Purpose: data-space decoder, bit access, 8-bit temp, NVM address
// Assumes: CPU holds a request only while busy_o is low
// Notes:   write timer runs on por_n_i so a system reset spares it
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
// Notes on behaviour
// - register file, I/O, extended I/O, then SRAM
// - extended I/O only by load and store
// - displacement adds up to 63 to Y/Z
// - X, Y, Z pointers from registers 26-31
// - pre-decrement and post-increment write pointer back
// - SRAM access takes two cycles
// - NVM bytes addressed linearly 0 to 1023
// - stall four cycles on read, two on write
// - pollable self-timed write busy indication
// - system reset never aborts a running write; power-on reset clears it
// - short I/O addresses 0-0x3F sit at +0x20
// - bit ops only at I/O 0x00-0x1F
// - bit ops touch only the addressed bit
// - write-one-to-clear flags clear on written one
// - three scratch registers, only the one at 0x3E bit-accessible
// - low byte to temp, high write loads both
// - low read copies high byte to temp
// - temp register directly readable and writable
// - 10-bit address register, low then high offset
// - write starts only within four armed cycles
// - read strobe loads addressed byte into data register
module data_space_io_decoder #(
  parameter int unsigned WR_CYCLES = `WR_TIME_US * `CLK_MHZ
) (
  // Clock and resets
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               por_n_i,
  // CPU request
  input  wire logic               req_i,
  input  wire dsd_pkg::acc_kind_e acc_i,
  input  wire dsd_pkg::adr_mode_e mode_i,
  input  wire dsd_pkg::ptr_sel_e  ptr_sel_i,
  input  wire logic               io_form_i,
  input  wire logic [15:0]        addr_i,
  input  wire logic [5:0]         disp_i,
  input  wire logic [2:0]         bit_sel_i,
  input  wire logic [7:0]         wdata_i,
  // CPU answer
  output logic                    busy_o,
  output logic                    ack_o,
  output logic [7:0]              rdata_o,
  output logic                    bit_o,
  // SRAM port
  output logic                    sram_en_o,
  output logic                    sram_we_o,
  output logic [`SRAM_AW-1:0]     sram_addr_o,
  output logic [7:0]              sram_wdata_o,
  input  wire logic [7:0]         sram_rdata_i,
  // Peripheral port
  output logic                    per_en_o,
  output logic                    per_we_o,
  output logic [7:0]              per_addr_o,
  output logic [7:0]              per_wdata_o,
  output logic [7:0]              per_wmask_o,
  input  wire logic [7:0]         per_rdata_i,
  // NVM array port
  output logic                    nvm_rd_o,
  output logic                    nvm_wr_o,
  output logic [`NVM_AW-1:0]      nvm_addr_o,
  output logic [7:0]              nvm_wdata_o,
  input  wire logic [7:0]         nvm_rdata_i
);
  import dsd_pkg::*;

  localparam int CW = $clog2(WR_CYCLES + 1);
  localparam logic [7:0] SCR_ADDR [3] = '{`A_SCR0, `A_SCR1, `A_SCR2};

  dec_state_e          state_reg, state_next;
  logic [2:0]          stall_reg, stall_next;
  logic [2:0]          arm_reg, arm_next;
  logic [7:0]          rf_reg [`RF_LOCS];
  logic [7:0]          rf_next [`RF_LOCS];
  logic [7:0]          rdata_reg, rdata_next;
  logic                bit_reg, bit_next;
  logic                ack_reg, ack_next;
  logic                sram_en_reg, sram_en_next;
  logic                sram_we_reg, sram_we_next;
  logic [`SRAM_AW-1:0] sram_addr_reg, sram_addr_next;
  logic [7:0]          sram_wdata_reg, sram_wdata_next;
  logic                nvm_rd_reg, nvm_rd_next;
  logic                nvm_wr_reg, nvm_wr_next;
  logic                done_reg, done_next;
  logic [7:0]          data_reg, data_next;
  logic [`NVM_AW-1:0]  addr_reg, addr_next;
  logic [7:0]          tmp_reg, tmp_next;
  logic [CW-1:0]       wr_cnt_reg, wr_cnt_next;
  logic [4:0]          pidx;
  logic [15:0]         ptr_val, eff_addr, ptr_new, io_addr, daddr;
  logic                ptr_upd, is_bit, bit_ok, refused, go, is_wr;
  logic                in_rf, in_per, in_sram, int_hit, int_we;
  logic                arm_on, arm_load, wr_start, wr_busy, wr_fin;
  logic [7:0]          wmask, wval, int_rd, ctrl_rd, rd;
  logic [7:0]          scr_q [3];
  logic [2:0]          scr_we;

  always_comb
  begin
    case (ptr_sel_i)
      PTR_X:   pidx = `PTR_X_IDX;
      PTR_Y:   pidx = `PTR_Y_IDX;
      default: pidx = `PTR_Z_IDX;
    endcase
  end
  assign ptr_val = {rf_reg[pidx + 5'd1], rf_reg[pidx]};

  ptr_unit u_ptr (
    .ptr_i    (ptr_val),
    .mode_i   (mode_i),
    .disp_i   (disp_i),
    .addr_i   (addr_i),
    .eff_o    (eff_addr),
    .upd_o    (ptr_new),
    .upd_en_o (ptr_upd)
  );

  // Short I/O form can never reach past 0x5F, so extended I/O stays
  // load/store only
  assign is_bit  = acc_i inside {ACC_BIT_SET, ACC_BIT_CLR, ACC_BIT_TEST};
  assign bit_ok  = addr_i[5:0] <= `BIT_IO_TOP;
  assign io_addr = {10'h000, addr_i[5:0]} + `IO_OFS;
  assign daddr   = (io_form_i || is_bit) ? io_addr : eff_addr;
  assign int_hit = daddr[15:8] == 8'h00 &&
                   daddr[7:0] inside {`A_SCR0, `A_CTRL, `A_DATA, `A_ADDR_L,
                                      `A_ADDR_H, `A_TEMP, `A_SCR1, `A_SCR2};
  assign in_rf   = daddr < `IO_BASE;
  assign in_per  = !in_rf && daddr < `SRAM_BASE && !int_hit;
  assign in_sram = daddr >= `SRAM_BASE && daddr < `SRAM_END;
  assign refused = is_bit && !bit_ok;
  assign go      = req_i && state_reg == ST_IDLE && !refused;
  assign is_wr   = acc_i inside {ACC_STORE, ACC_BIT_SET, ACC_BIT_CLR};
  assign wmask   = (acc_i == ACC_BIT_SET || acc_i == ACC_BIT_CLR) ?
                   8'h01 << bit_sel_i : 8'hff;
  assign wval    = acc_i == ACC_BIT_SET ? 8'hff :
                   acc_i == ACC_BIT_CLR ? 8'h00 : wdata_i;
  assign int_we  = go && is_wr && int_hit;
  assign arm_on  = arm_reg != 3'd0;

  // Peripherals see the mask and handle their own write-one-to-clear
  assign per_en_o    = go && in_per;
  assign per_we_o    = go && in_per && is_wr;
  assign per_addr_o  = daddr[7:0];
  assign per_wdata_o = wval & wmask;
  assign per_wmask_o = wmask;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_scr
      assign scr_we[gi] = int_we && daddr[7:0] == SCR_ADDR[gi];
      scratch_reg u_scr (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .we_i      (scr_we[gi]),
        .mask_i    (wmask),
        .val_i     (wval),
        .q_o       (scr_q[gi])
      );
    end
  endgenerate

  always_comb
  begin
    ctrl_rd = 8'h00;
    ctrl_rd[`B_DONE] = done_reg;
    ctrl_rd[`B_ARM]  = arm_on;
    ctrl_rd[`B_WR]   = wr_busy;
    case (daddr[7:0])
      `A_CTRL:   int_rd = ctrl_rd;
      `A_DATA:   int_rd = data_reg;
      `A_ADDR_L: int_rd = addr_reg[7:0];
      `A_ADDR_H: int_rd = tmp_reg;
      `A_TEMP:   int_rd = tmp_reg;
      `A_SCR0:   int_rd = scr_q[0];
      `A_SCR1:   int_rd = scr_q[1];
      `A_SCR2:   int_rd = scr_q[2];
      default:   int_rd = 8'h00;
    endcase
    // Unmapped space reads zero and ignores writes
    if (in_rf)
      rd = rf_reg[daddr[4:0]];
    else if (int_hit)
      rd = int_rd;
    else if (in_per)
      rd = per_rdata_i;
    else
      rd = 8'h00;
  end

  always_comb
  begin
    state_next      = state_reg;
    stall_next      = stall_reg;
    arm_next        = arm_on ? arm_reg - 3'd1 : 3'd0;
    arm_load        = 1'b0;
    rf_next         = rf_reg;
    rdata_next      = rdata_reg;
    bit_next        = bit_reg;
    ack_next        = 1'b0;
    sram_en_next    = 1'b0;
    sram_we_next    = 1'b0;
    sram_addr_next  = sram_addr_reg;
    sram_wdata_next = sram_wdata_reg;
    nvm_rd_next     = 1'b0;
    nvm_wr_next     = 1'b0;
    wr_start        = 1'b0;
    done_next       = done_reg;
    data_next       = data_reg;
    addr_next       = addr_reg;
    tmp_next        = tmp_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (go)
        begin
          if (in_sram)
          begin
            state_next      = ST_SRAM;
            sram_en_next    = 1'b1;
            sram_we_next    = is_wr;
            sram_addr_next  = `SRAM_AW'(daddr - `SRAM_BASE);
            sram_wdata_next = wdata_i;
          end
          else
          begin
            ack_next   = 1'b1;
            rdata_next = rd;
            bit_next   = rd[bit_sel_i];
          end
          if (ptr_upd)
          begin
            rf_next[pidx]        = ptr_new[7:0];
            rf_next[pidx + 5'd1] = ptr_new[15:8];
          end
          if (in_rf && is_wr)
            rf_next[daddr[4:0]] = wdata_i;
          if (!is_wr && int_hit && daddr[7:0] == `A_ADDR_L)
            tmp_next = {6'h00, addr_reg[9:8]};
          if (int_we)
          begin
            case (daddr[7:0])
              `A_CTRL:
              begin
                if (wmask[`B_ARM] && wval[`B_ARM])
                begin
                  arm_next = `ARM_CYCLES;
                  arm_load = 1'b1;
                end
                if (wmask[`B_DONE] && wval[`B_DONE])
                  done_next = 1'b0;
                if (wmask[`B_WR] && wval[`B_WR] && arm_on && !wr_busy)
                begin
                  wr_start    = 1'b1;
                  nvm_wr_next = 1'b1;
                  state_next  = ST_STALL;
                  stall_next  = `WR_STALL;
                end
                else if (wmask[`B_RD] && wval[`B_RD] && !wr_busy)
                begin
                  nvm_rd_next = 1'b1;
                  state_next  = ST_STALL;
                  stall_next  = `RD_STALL;
                end
              end
              `A_DATA:   data_next = (data_reg & ~wmask) | (wval & wmask);
              `A_ADDR_L: tmp_next = wval;
              `A_ADDR_H:
              begin
                // Address frozen while a write is running
                if (!wr_busy)
                  addr_next = {wval[1:0], tmp_reg};
              end
              `A_TEMP:   tmp_next = wval;
              default:   ;
            endcase
          end
        end
      end
      ST_SRAM:
      begin
        ack_next   = 1'b1;
        rdata_next = sram_rdata_i;
        bit_next   = 1'b0;
        state_next = ST_IDLE;
      end
      ST_STALL:
      begin
        if (nvm_rd_reg)
          data_next = nvm_rdata_i;
        stall_next = stall_reg - 3'd1;
        if (stall_reg == 3'd1)
          state_next = ST_IDLE;
      end
      default:   state_next = ST_IDLE;
    endcase
    if (wr_fin)
      done_next = 1'b1;
  end

  // Address reset value is only for a clean simulation start
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg      <= ST_IDLE;
      stall_reg      <= 3'd0;
      arm_reg        <= 3'd0;
      rf_reg         <= '{default: 8'h00};
      rdata_reg      <= 8'h00;
      bit_reg        <= 1'b0;
      ack_reg        <= 1'b0;
      sram_en_reg    <= 1'b0;
      sram_we_reg    <= 1'b0;
      sram_addr_reg  <= '0;
      sram_wdata_reg <= 8'h00;
      nvm_rd_reg     <= 1'b0;
      nvm_wr_reg     <= 1'b0;
      done_reg       <= 1'b0;
      data_reg       <= 8'h00;
      addr_reg       <= '0;
      tmp_reg        <= 8'h00;
    end
    else
    begin
      state_reg      <= state_next;
      stall_reg      <= stall_next;
      arm_reg        <= arm_next;
      rf_reg         <= rf_next;
      rdata_reg      <= rdata_next;
      bit_reg        <= bit_next;
      ack_reg        <= ack_next;
      sram_en_reg    <= sram_en_next;
      sram_we_reg    <= sram_we_next;
      sram_addr_reg  <= sram_addr_next;
      sram_wdata_reg <= sram_wdata_next;
      nvm_rd_reg     <= nvm_rd_next;
      nvm_wr_reg     <= nvm_wr_next;
      done_reg       <= done_next;
      data_reg       <= data_next;
      addr_reg       <= addr_next;
      tmp_reg        <= tmp_next;
    end
  end

  // Write timer: only power-on clears it
  always_comb
  begin
    wr_cnt_next = wr_cnt_reg;
    if (wr_start)
      wr_cnt_next = CW'(WR_CYCLES);
    else if (wr_busy)
      wr_cnt_next = wr_cnt_reg - CW'(1);
  end
  assign wr_busy = wr_cnt_reg != '0;
  assign wr_fin  = wr_cnt_reg == CW'(1);

  always_ff @(posedge clk_i or negedge por_n_i)
  begin
    if (!por_n_i)
      wr_cnt_reg <= '0;
    else
      wr_cnt_reg <= wr_cnt_next;
  end

  assign busy_o       = state_reg != ST_IDLE;
  assign ack_o        = ack_reg;
  assign rdata_o      = rdata_reg;
  assign bit_o        = bit_reg;
  assign sram_en_o    = sram_en_reg;
  assign sram_we_o    = sram_we_reg;
  assign sram_addr_o  = sram_addr_reg;
  assign sram_wdata_o = sram_wdata_reg;
  assign nvm_rd_o     = nvm_rd_reg;
  assign nvm_wr_o     = nvm_wr_reg;
  assign nvm_addr_o   = addr_reg;
  assign nvm_wdata_o  = data_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_sram_go;
    go && in_sram;
  endsequence
  sequence s_arm_run;
    (arm_reg == 3'd4 && !arm_load) ##1 (!arm_load)[*3];
  endsequence

  a_sram_two_cycle: assert property (s_sram_go |=>
    state_reg == ST_SRAM && !ack_o ##1 ack_o)
    else $error("SRAM access not two cycles");
  a_read_stall: assert property (nvm_rd_o |->
    busy_o[*4] ##1 !busy_o)
    else $error("NVM read stall not four cycles");
  a_write_stall: assert property (nvm_wr_o |->
    busy_o[*2] ##1 !busy_o)
    else $error("NVM write stall not two cycles");
  a_arm_needed: assert property (nvm_wr_o |->
    $past(arm_reg) != 3'd0 && wr_busy)
    else $error("Write started without arming");
  a_arm_timeout: assert property (s_arm_run |=>
    arm_reg == 3'd0)
    else $error("Arm window not four cycles");
  a_ptr_postinc: assert property (go && mode_i == ADR_POSTINC &&
    !(in_rf && is_wr) |=> {rf_reg[$past(pidx) + 5'd1],
    rf_reg[$past(pidx)]} == $past(ptr_val) + 16'h0001)
    else $error("Pointer not incremented");
  a_ptr_predec: assert property (go && mode_i == ADR_PREDEC &&
    !(in_rf && is_wr) |-> daddr == ptr_val - 16'h0001)
    else $error("Pre-decrement address wrong");
  a_high_write: assert property (int_we && daddr[7:0] == `A_ADDR_H &&
    !wr_busy |=> addr_reg == {$past(wval[1:0]), $past(tmp_reg)})
    else $error("High byte write not atomic");
  a_low_read: assert property (go && !is_wr && int_hit &&
    daddr[7:0] == `A_ADDR_L |=> tmp_reg == {6'h00, $past(addr_reg[9:8])})
    else $error("Low read did not copy high byte");
  a_bit_single: assert property (per_we_o && is_bit |->
    $onehot(per_wmask_o))
    else $error("Bit op touched several bits");
  a_bit_range: assert property (req_i && refused && !busy_o |->
    !per_en_o ##1 !ack_o)
    else $error("Bit op above 0x1F acted");
  a_done_flag: assert property (wr_fin |=> done_reg)
    else $error("Write end not flagged");
  a_write_survives: assert property (@(posedge clk_i)
    disable iff (!por_n_i) wr_busy && !wr_fin |=> wr_busy)
    else $error("Running write aborted");
endmodule
`default_nettype wire

// ===== common/dsd_defs.svh
// Purpose: offsets, field positions and timing counts of the decoder
// Assumes: data addresses are 16 bits, I/O offsets 8 bits
// Notes:   shared by the decoder, the far-side stores and the bench
`ifndef DSD_DEFS_SVH
`define DSD_DEFS_SVH
`define RF_LOCS     32
`define IO_BASE     16'h0020
`define EXT_BASE    16'h0060
`define SRAM_BASE   16'h0100
`define SRAM_END    16'h1100
`define SRAM_AW     12
`define IO_OFS      16'h0020
`define BIT_IO_TOP  6'h1f
`define PTR_X_IDX   5'd26
`define PTR_Y_IDX   5'd28
`define PTR_Z_IDX   5'd30
`define A_SCR0      8'h3e
`define A_CTRL      8'h3f
`define A_DATA      8'h40
`define A_ADDR_L    8'h41
`define A_ADDR_H    8'h42
`define A_TEMP      8'h43
`define A_SCR1      8'h4a
`define A_SCR2      8'h4b
`define B_RD        0
`define B_WR        1
`define B_ARM       2
`define B_DONE      7
`define NVM_AW      10
`define ARM_CYCLES  3'd4
`define RD_STALL    3'd4
`define WR_STALL    3'd2
`define WR_TIME_US  3400
`define CLK_MHZ     10
`endif

// ===== common/dsd_pkg.sv
// Purpose: types of the data-space decoder
// Assumes: nothing
// Notes:   constants live in dsd_defs.svh
`default_nettype none
package dsd_pkg;
  typedef enum logic [2:0] {ACC_LOAD, ACC_STORE, ACC_BIT_SET,
                            ACC_BIT_CLR, ACC_BIT_TEST} acc_kind_e;
  typedef enum logic [2:0] {ADR_DIRECT, ADR_IND, ADR_DISP,
                            ADR_PREDEC, ADR_POSTINC} adr_mode_e;
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_sel_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SRAM, ST_STALL} dec_state_e;
endpackage
`default_nettype wire

// ===== rtl/ptr_unit.sv
// Purpose: effective address and pointer update for one access
// Assumes: pointer value already gathered from the register file
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module ptr_unit (
  // Request
  input  wire logic [15:0]        ptr_i,
  input  wire dsd_pkg::adr_mode_e mode_i,
  input  wire logic [5:0]         disp_i,
  input  wire logic [15:0]        addr_i,
  // Results
  output logic [15:0]             eff_o,
  output logic [15:0]             upd_o,
  output logic                    upd_en_o
);
  import dsd_pkg::*;

  always_comb
  begin
    eff_o    = ptr_i;
    upd_o    = ptr_i;
    upd_en_o = 1'b0;
    case (mode_i)
      ADR_DIRECT:  eff_o = addr_i;
      ADR_IND:     eff_o = ptr_i;
      ADR_DISP:    eff_o = ptr_i + {10'h000, disp_i};
      ADR_PREDEC:
      begin
        upd_o    = ptr_i - 16'h0001;
        eff_o    = ptr_i - 16'h0001;
        upd_en_o = 1'b1;
      end
      ADR_POSTINC:
      begin
        upd_o    = ptr_i + 16'h0001;
        upd_en_o = 1'b1;
      end
      default:     eff_o = addr_i;
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/scratch_reg.sv
// Purpose: one general-purpose byte register with per-bit write mask
// Assumes: decode done by the caller
// Notes:   mask lets single-bit writes leave the other bits alone
`timescale 1ns/1ps
`default_nettype none
module scratch_reg (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Write port
  input  wire logic       we_i,
  input  wire logic [7:0] mask_i,
  input  wire logic [7:0] val_i,
  // Contents
  output logic [7:0]      q_o
);
  logic [7:0] q_reg;
  logic [7:0] q_next;

  always_comb
  begin
    q_next = q_reg;
    if (we_i)
      q_next = (q_reg & ~mask_i) | (val_i & mask_i);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      q_reg <= 8'h00;
    else
      q_reg <= q_next;
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

// ===== sim/far_mem.sv
// Purpose: far-side stores: data SRAM, peripheral bytes, NVM array
// Assumes: wired straight to the decoder's memory and peripheral ports
// Notes:   NVM has no timing; the decoder owns the write timer
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
module far_mem (
  // Clock
  input  wire logic               clk_i,
  // SRAM
  input  wire logic               sram_en_i,
  input  wire logic               sram_we_i,
  input  wire logic [`SRAM_AW-1:0] sram_addr_i,
  input  wire logic [7:0]         sram_wdata_i,
  output logic [7:0]              sram_rdata_o,
  // Peripheral
  input  wire logic               per_en_i,
  input  wire logic               per_we_i,
  input  wire logic [7:0]         per_addr_i,
  input  wire logic [7:0]         per_wdata_i,
  input  wire logic [7:0]         per_wmask_i,
  output logic [7:0]              per_rdata_o,
  // NVM array
  input  wire logic               nvm_rd_i,
  input  wire logic               nvm_wr_i,
  input  wire logic [`NVM_AW-1:0] nvm_addr_i,
  input  wire logic [7:0]         nvm_wdata_i,
  output logic [7:0]              nvm_rdata_o
);
  logic [7:0] sram [0:(1<<`SRAM_AW)-1];
  logic [7:0] pmem [0:255];
  logic [7:0] nvm  [0:(1<<`NVM_AW)-1];
  // Deselected bus shows inverted data, so a stale value never matches
  assign sram_rdata_o = sram_en_i ? sram[sram_addr_i] : ~sram[sram_addr_i];
  assign per_rdata_o  = per_en_i ? pmem[per_addr_i] : ~pmem[per_addr_i];
  assign nvm_rdata_o  = nvm_rd_i ? nvm[nvm_addr_i] : ~nvm[nvm_addr_i];
  always @(posedge clk_i)
  begin
    if (sram_en_i && sram_we_i)
      sram[sram_addr_i] <= sram_wdata_i;
    // Masked write keeps untouched bits
    if (per_en_i && per_we_i)
      pmem[per_addr_i] <= (pmem[per_addr_i] & ~per_wmask_i) | per_wdata_i;
    if (nvm_wr_i)
      nvm[nvm_addr_i] <= nvm_wdata_i;
  end
endmodule
`default_nettype wire

// ===== sim/data_space_io_decoder_tb_top.sv
// Purpose: directed bench of the data-space decoder
// Assumes: WR_CYCLES shortened to 20
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
module data_space_io_decoder_tb_top;
  import dsd_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, por_n_i = 1'b0, req_i = 1'b0;
  acc_kind_e acc_i = ACC_LOAD;
  adr_mode_e mode_i = ADR_DIRECT;
  ptr_sel_e ptr_sel_i = PTR_X;
  logic io_form_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [5:0] disp_i = 6'h00;
  logic [2:0] bit_sel_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic busy_o, ack_o, bit_o, sram_en_o, sram_we_o, per_en_o, per_we_o;
  logic nvm_wr_o, nvm_rd_o;
  logic [`SRAM_AW-1:0] sram_addr_o;
  logic [`NVM_AW-1:0] nvm_addr_o;
  logic [7:0] rdata_o, sram_wdata_o, sram_rdata_i, per_addr_o, per_wdata_o;
  logic [7:0] per_wmask_o, per_rdata_i, nvm_wdata_o, nvm_rdata_i;
  logic [7:0] rd, pa, pm;
  logic bt, pe, ak;
  int lat, bsy, n, wr_cnt = 0, miscompares = 0, tests_run = 0;

  data_space_io_decoder #(.WR_CYCLES(20)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i),
    .req_i(req_i), .acc_i(acc_i), .mode_i(mode_i), .ptr_sel_i(ptr_sel_i),
    .io_form_i(io_form_i), .addr_i(addr_i), .disp_i(disp_i),
    .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .busy_o(busy_o),
    .ack_o(ack_o), .rdata_o(rdata_o), .bit_o(bit_o),
    .sram_en_o(sram_en_o), .sram_we_o(sram_we_o),
    .sram_addr_o(sram_addr_o), .sram_wdata_o(sram_wdata_o),
    .sram_rdata_i(sram_rdata_i), .per_en_o(per_en_o),
    .per_we_o(per_we_o), .per_addr_o(per_addr_o),
    .per_wdata_o(per_wdata_o), .per_wmask_o(per_wmask_o),
    .per_rdata_i(per_rdata_i), .nvm_rd_o(nvm_rd_o), .nvm_wr_o(nvm_wr_o),
    .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o),
    .nvm_rdata_i(nvm_rdata_i));

  far_mem mem_m (
    .clk_i(clk_i), .sram_en_i(sram_en_o), .sram_we_i(sram_we_o),
    .sram_addr_i(sram_addr_o), .sram_wdata_i(sram_wdata_o),
    .sram_rdata_o(sram_rdata_i), .per_en_i(per_en_o),
    .per_we_i(per_we_o), .per_addr_i(per_addr_o),
    .per_wdata_i(per_wdata_o), .per_wmask_i(per_wmask_o),
    .per_rdata_o(per_rdata_i), .nvm_rd_i(nvm_rd_o), .nvm_wr_i(nvm_wr_o),
    .nvm_addr_i(nvm_addr_o), .nvm_wdata_i(nvm_wdata_o),
    .nvm_rdata_o(nvm_rdata_i));

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (nvm_wr_o === 1'b1)
      wr_cnt <= wr_cnt + 1;

  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One pulse request; lat counts edges to ack, bsy the stall after it
  task automatic acc(input acc_kind_e k, input adr_mode_e m,
    input ptr_sel_e p, input logic io, input logic [15:0] a,
    input logic [5:0] d, input logic [2:0] b, input logic [7:0] w,
    input logic ea);
    @(negedge clk_i);
    repeat (40) if (busy_o !== 1'b0) @(negedge clk_i);
    req_i = 1'b1;
    acc_i = k;
    mode_i = m;
    ptr_sel_i = p;
    io_form_i = io;
    addr_i = a;
    disp_i = d;
    bit_sel_i = b;
    wdata_i = w;
    #1;
    pe = per_en_o;
    pa = per_addr_o;
    pm = per_wmask_o;
    @(negedge clk_i);
    req_i = 1'b0;
    lat = 1;
    while (ack_o !== 1'b1 && lat < 6)
    begin
      lat++;
      @(negedge clk_i);
    end
    ak = ack_o;
    rd = rdata_o;
    bt = bit_o;
    bsy = 0;
    while (busy_o === 1'b1 && bsy < 8)
    begin
      bsy++;
      @(negedge clk_i);
    end
    // Missing answer or endless stall ends the run as a failure
    if ((ea && ak !== 1'b1) || busy_o !== 1'b0)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic st(input logic [15:0] a, input logic [7:0] w);
    acc(ACC_STORE, ADR_DIRECT, PTR_X, 1'b0, a, 6'h00, 3'h0, w, 1'b1);
  endtask
  task automatic ld(input logic [15:0] a);
    acc(ACC_LOAD, ADR_DIRECT, PTR_X, 1'b0, a, 6'h00, 3'h0, 8'h00, 1'b1);
  endtask
  task automatic bo(input acc_kind_e k, input logic [5:0] a,
    input logic [2:0] b, input logic ea);
    acc(k, ADR_DIRECT, PTR_X, 1'b1, {10'h000, a}, 6'h00, b, 8'h00, ea);
  endtask
  task automatic pt(input acc_kind_e k, input adr_mode_e m,
    input ptr_sel_e p, input logic [5:0] d, input logic [7:0] w);
    acc(k, m, p, 1'b0, 16'h0000, d, 3'h0, w, 1'b1);
  endtask

  initial
  begin
    repeat (20000) @(negedge clk_i);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    mem_m.nvm[10'h334] = 8'hc3;
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    por_n_i = 1'b1;
    st(16'h0005, 8'h3c);
    ld(16'h0005);
    chk(rd, 8'h3c);
    chk(lat, 1);
    acc(ACC_STORE, ADR_DIRECT, PTR_X, 1'b1, 16'h0010, 6'h00, 3'h0,
        8'h3c, 1'b1);
    chk({pe, pa}, 9'h130);
    ld(16'h0030);
    chk(rd, 8'h3c);
    st(16'h0060, 8'h81);
    chk({pe, pa}, 9'h160);
    st(16'h10ff, 8'h5e);
    chk(lat, 2);
    ld(16'h10ff);
    chk({lat[3:0], rd}, 12'h25e);
    ld(16'h1100);
    chk(rd, 8'h00);
    // Pointer modes; X = 0x0110
    st(16'h001a, 8'h10);
    st(16'h001b, 8'h01);
    pt(ACC_STORE, ADR_POSTINC, PTR_X, 6'h00, 8'haa);
    ld(16'h001a);
    chk(rd, 8'h11);
    ld(16'h0110);
    chk(rd, 8'haa);
    pt(ACC_LOAD, ADR_PREDEC, PTR_X, 6'h00, 8'h00);
    chk(rd, 8'haa);
    ld(16'h001a);
    chk(rd, 8'h10);
    st(16'h001c, 8'h00);
    st(16'h001d, 8'h01);
    pt(ACC_STORE, ADR_DISP, PTR_Y, 6'h3f, 8'h55);
    ld(16'h013f);
    chk(rd, 8'h55);
    st(16'h001e, 8'h10);
    st(16'h001f, 8'h01);
    pt(ACC_LOAD, ADR_IND, PTR_Z, 6'h00, 8'h00);
    chk(rd, 8'haa);
    // Scratch bytes and single-bit access
    st(16'h003e, 8'hf0);
    bo(ACC_BIT_SET, 6'h1e, 3'd0, 1'b1);
    bo(ACC_BIT_CLR, 6'h1e, 3'd4, 1'b1);
    ld(16'h003e);
    chk(rd, 8'he1);
    bo(ACC_BIT_TEST, 6'h1e, 3'd5, 1'b1);
    chk(bt, 1'b1);
    st(16'h004a, 8'h12);
    st(16'h004b, 8'h34);
    ld(16'h004a);
    chk(rd, 8'h12);
    ld(16'h004b);
    chk(rd, 8'h34);
    bo(ACC_BIT_SET, 6'h05, 3'd5, 1'b1);
    chk({pa, pm}, 16'h2520);
    bo(ACC_BIT_SET, 6'h23, 3'd0, 1'b0);
    chk(ak, 1'b0);
    // Address pair through the shared temp
    st(16'h0041, 8'h34);
    ld(16'h0043);
    chk(rd, 8'h34);
    st(16'h0042, 8'hff);
    chk(nvm_addr_o, 10'h334);
    st(16'h0043, 8'h00);
    ld(16'h0041);
    chk(rd, 8'h34);
    ld(16'h0043);
    chk(rd, 8'h03);
    ld(16'h0042);
    chk(rd, 8'h03);
    // Read strobe, then writes unarmed, late and proper
    st(16'h003f, 8'h01);
    chk(bsy, 4);
    ld(16'h0040);
    chk(rd, 8'hc3);
    st(16'h0040, 8'h5a);
    st(16'h003f, 8'h02);
    chk(bsy, 0);
    st(16'h003f, 8'h04);
    repeat (3) @(negedge clk_i);
    bo(ACC_BIT_SET, 6'h1f, 3'd1, 1'b1);
    chk(wr_cnt, 0);
    st(16'h003f, 8'h04);
    bo(ACC_BIT_SET, 6'h1f, 3'd1, 1'b1);
    chk(bsy, 2);
    chk(wr_cnt, 1);
    bo(ACC_BIT_TEST, 6'h1f, 3'd1, 1'b1);
    chk(bt, 1'b1);
    n = 0;
    do
    begin
      ld(16'h003f);
      n++;
    end
    while (rd[1] === 1'b1 && n < 30);
    chk({rd[7], rd[1]}, 2'b10);
    chk(mem_m.nvm[10'h334], 8'h5a);
    st(16'h003f, 8'h80);
    ld(16'h003f);
    chk(rd[7], 1'b0);
    // System reset in mid-write must spare it
    st(16'h003f, 8'h04);
    bo(ACC_BIT_SET, 6'h1f, 3'd1, 1'b1);
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    ld(16'h003f);
    chk(rd[1], 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
